// ### rtl/ecc_engine.sv
// Purpose: stand-in eeprom transaction engine with timeout
// Assumes: eeprom presence is a synchronised level
// Notes: models a fixed transfer time; real i2c master sits here
`timescale 1ns/1ps
module ecc_engine #(
  parameter int XFER_CYC = 32,
  parameter int TIMEOUT_CYC = ecc_pkg::TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic present,
  input wire ecc_pkg::ecc_req_t req,
  output ecc_pkg::ecc_rsp_t rsp
);
  typedef enum logic [1:0] {
    EE_IDLE = 2'b00,
    EE_RUN = 2'b01
  } ecc_eng_t;
  ecc_eng_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [7:0] mem_q, mem_d;
  ecc_pkg::ecc_rsp_t rsp_q, rsp_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    mem_d = mem_q;
    rsp_d = '0;
    rsp_d.rdata = rsp_q.rdata;
    unique case (st_q)
      EE_IDLE: begin
        if (req.start) begin
          st_d = EE_RUN;
          cnt_d = '0;
          wr_d = req.write;
          if (req.write) begin
            mem_d = req.wdata;
          end
        end
      end
      EE_RUN: begin
        cnt_d = cnt_q + 16'h0001;
        if (present && cnt_q == 16'(XFER_CYC - 1)) begin
          st_d = EE_IDLE;
          rsp_d.done = 1'b1;
          if (!wr_q) begin
            rsp_d.rdata = mem_q;
          end
        end else if (cnt_q == 16'(TIMEOUT_CYC - 1)) begin
          // absent device never acks; give up
          st_d = EE_IDLE;
          rsp_d.done = 1'b1;
          rsp_d.timeout = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= EE_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      mem_q <= 8'hFF;
      rsp_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      mem_q <= mem_d;
      rsp_q <= rsp_d;
    end
  end
  assign rsp = rsp_q;
endmodule // ecc_engine

// ### rtl/ecc_pkg.sv
// Purpose: shared constants and types for the eeprom command controller
// Assumes: 32-bit axi4-lite register bus, 25 MHz aclk
// Notes: offsets are byte addresses
package ecc_pkg;
  localparam logic [11:0] CMD_OFF = 12'h1B4;
  localparam logic [11:0] BYTE_OFF = 12'h1B8;
  localparam logic [11:0] STAT_OFF = 12'h1C0;
  localparam int BUSY_BIT = 31;
  localparam int OP_HI = 30;
  localparam int OP_LO = 28;
  localparam int ADDR_W = 16;
  localparam logic [2:0] OP_RESET = 3'h0;
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam int TIMEOUT_US = 30;
  localparam int CLK_MHZ = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int LOAD_CYC = 64;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic busy;
    logic [2:0] op;
    logic [ADDR_W-1:0] addr;
  } ecc_cmd_t;

  typedef struct packed {
    logic start;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } ecc_req_t;

  typedef struct packed {
    logic done;
    logic timeout;
    logic [7:0] rdata;
  } ecc_rsp_t;
endpackage

// ### rtl/ecc_top.sv
// Purpose: eeprom command register, busy handshake and axi4-lite slave
// Assumes: single aclk, synchronous active-low reset
// Notes: loader modelled as a fixed delay after reset
// Functional notes
// - writing one to bit 31 launches selected operation at given address
// - busy stays set until the operation completes, then self-clears
// - on read, busy clearing with no timeout flag means the byte register holds valid data
// - write with no eeprom keeps busy until timeout flag, then clears
// - busy forced to one after power-up, pin reset or digital reset
// - busy clears after reset only when the automatic loader finishes
// - the op code in bits 30:28, reset 000, runs when busy is set
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ecc_top #(
  parameter int LOAD_CYC = ecc_pkg::LOAD_CYC,
  parameter int TIMEOUT_CYC = ecc_pkg::TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic eeprom_present,
  input wire logic digital_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  logic pres_m_q, pres_q;
  logic drst_m_q, drst_q;
  logic loading_q, loading_d;
  logic [15:0] load_cnt_q, load_cnt_d;
  ecc_pkg::ecc_cmd_t cmd_q, cmd_d;
  logic [7:0] byte_q, byte_d;
  logic tmo_q, tmo_d;
  logic start_q, start_d;
  ecc_pkg::ecc_req_t req;
  ecc_pkg::ecc_rsp_t rsp;
  logic aw_q, aw_d, w_q, w_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic bv_q, bv_d, rv_q, rv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  logic wr_fire, rd_fire;

  function automatic logic mapped(input logic [11:0] a);
    return a == ecc_pkg::CMD_OFF || a == ecc_pkg::BYTE_OFF || a == ecc_pkg::STAT_OFF;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // external levels are asynchronous: two flops each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pres_m_q <= 1'b0;
      pres_q <= 1'b0;
      drst_m_q <= 1'b0;
      drst_q <= 1'b0;
    end else begin
      pres_m_q <= eeprom_present;
      pres_q <= pres_m_q;
      drst_m_q <= digital_rst;
      drst_q <= drst_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi channel capture
  assign wr_fire = aw_q && w_q && !bv_q;
  assign rd_fire = s_axi_arvalid && !rv_q;

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awa_d = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = mapped(awa_q) ? ecc_pkg::RESP_OKAY : ecc_pkg::RESP_SLVERR;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (rd_fire) begin
      rv_d = 1'b1;
      rr_d = ecc_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[11:2], 2'b00})
        ecc_pkg::CMD_OFF: rd_d = {cmd_q.busy, cmd_q.op, 12'h000, cmd_q.addr};
        ecc_pkg::BYTE_OFF: rd_d = {24'h000000, byte_q};
        ecc_pkg::STAT_OFF: rd_d = {30'h0, loading_q, tmo_q};
        default: begin
          rd_d = 32'h00000000;
          rr_d = ecc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command, byte, timeout and loader state
  always_comb begin
    cmd_d = cmd_q;
    byte_d = byte_q;
    tmo_d = tmo_q;
    start_d = 1'b0;
    loading_d = loading_q;
    load_cnt_d = load_cnt_q;
    if (loading_q) begin
      load_cnt_d = load_cnt_q + 16'h0001;
      if (load_cnt_q == 16'(LOAD_CYC - 1)) begin
        loading_d = 1'b0;
        cmd_d.busy = 1'b0;
      end
    end
    if (rsp.done) begin
      cmd_d.busy = 1'b0;
      if (rsp.timeout) begin
        tmo_d = 1'b1;
      end else if (!req.write) begin
        byte_d = rsp.rdata;
      end
    end
    // reserved code: engine never starts, so busy must drop here or hang
    if (start_q && !req.start) begin
      cmd_d.busy = 1'b0;
    end
    // writes while busy are dropped so a running op cannot be disturbed
    if (wr_fire && !cmd_q.busy) begin
      if (awa_q == ecc_pkg::CMD_OFF) begin
        if (ws_q[3]) begin
          cmd_d.op = wd_q[ecc_pkg::OP_HI:ecc_pkg::OP_LO];
          if (wd_q[ecc_pkg::BUSY_BIT]) begin
            cmd_d.busy = 1'b1;
            start_d = 1'b1;
          end
        end
        if (ws_q[1]) cmd_d.addr[15:8] = wd_q[15:8];
        if (ws_q[0]) cmd_d.addr[7:0] = wd_q[7:0];
      end else if (awa_q == ecc_pkg::BYTE_OFF && ws_q[0]) begin
        byte_d = wd_q[7:0];
      end else if (awa_q == ecc_pkg::STAT_OFF && ws_q[0] && wd_q[0]) begin
        tmo_d = 1'b0;
      end
    end
    if (rsp.done && rsp.timeout) begin
      tmo_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || drst_q) begin
      cmd_q <= '{busy: 1'b1, op: ecc_pkg::OP_RESET, addr: '0};
      byte_q <= 8'h00;
      tmo_q <= 1'b0;
      start_q <= 1'b0;
      loading_q <= 1'b1;
      load_cnt_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      byte_q <= byte_d;
      tmo_q <= tmo_d;
      start_q <= start_d;
      loading_q <= loading_d;
      load_cnt_q <= load_cnt_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      bv_q <= 1'b0;
      br_q <= ecc_pkg::RESP_OKAY;
      rv_q <= 1'b0;
      rr_q <= ecc_pkg::RESP_OKAY;
      rd_q <= '0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reserved codes start nothing and clear at once
  always_comb begin
    req.start = start_q && (cmd_q.op == ecc_pkg::OP_READ || cmd_q.op == ecc_pkg::OP_WRITE);
    req.write = cmd_q.op == ecc_pkg::OP_WRITE;
    req.addr = cmd_q.addr;
    req.wdata = byte_q;
  end

  ecc_engine #(
    .XFER_CYC(32),
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_engine (
    .aclk(aclk),
    .aresetn(aresetn && !drst_q),
    .present(pres_q),
    .req(req),
    .rsp(rsp)
  );

  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp = rr_q;
  assign s_axi_rdata = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_busy_reset;
    @(posedge aclk) !aresetn |=> cmd_q.busy;
  endproperty
  a_busy_reset: assert property (p_busy_reset) else $error("busy not set after reset");

  property p_launch;
    @(posedge aclk) disable iff (!aresetn || drst_q)
      (wr_fire && !cmd_q.busy && awa_q == ecc_pkg::CMD_OFF && ws_q[3] && wd_q[31])
      |=> cmd_q.busy && start_q;
  endproperty
  a_launch: assert property (p_launch) else $error("launch missed");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn || drst_q)
      (cmd_q.busy && !loading_q && !rsp.done && !(start_q && !req.start)) |=> cmd_q.busy;
  endproperty
  a_hold: assert property (p_hold) else $error("busy dropped early");

  property p_read_valid;
    @(posedge aclk) disable iff (!aresetn || drst_q)
      (rsp.done && !rsp.timeout && !req.write) |=> (byte_q == $past(rsp.rdata)) && !cmd_q.busy;
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("read byte not valid");

  property p_timeout;
    @(posedge aclk) disable iff (!aresetn || drst_q)
      (rsp.done && rsp.timeout) |=> tmo_q && !cmd_q.busy;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not clear busy");

  property p_loader;
    @(posedge aclk) disable iff (!aresetn || drst_q)
      loading_q |-> cmd_q.busy;
  endproperty
  a_loader: assert property (p_loader) else $error("busy clear during load");

  property p_op_hold;
    @(posedge aclk) disable iff (!aresetn || drst_q)
      (cmd_q.busy && $past(cmd_q.busy)) |-> $stable(cmd_q.op);
  endproperty
  a_op_hold: assert property (p_op_hold) else $error("op changed while busy");

  property p_reserved;
    @(posedge aclk) disable iff (!aresetn)
      req.start |-> (cmd_q.op == 3'h0 || cmd_q.op == 3'h3);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code started");

  c_read: cover property (@(posedge aclk) rsp.done && !rsp.timeout && !req.write);
  c_write: cover property (@(posedge aclk) rsp.done && !rsp.timeout && req.write);
  c_tmo: cover property (@(posedge aclk) rsp.done && rsp.timeout);
endmodule // ecc_top

// ### tb/ecc_eeprom_model.sv
// Purpose: far-side eeprom presence for the command controller bench
// Assumes: attach is a level set by the bench
// Notes: only presence is visible at the block's pins
`timescale 1ns/1ps
module ecc_eeprom_model (
  input wire logic aclk,
  input wire logic attach,
  output logic present
);
  // registered so presence never changes in the bench's own time step
  always_ff @(posedge aclk) begin
    present <= attach;
  end
endmodule // ecc_eeprom_model

// ### tb/tb_top.sv
// Purpose: self-checking bench for the eeprom command controller
// Assumes: short loader and timeout counts for a fast run
// Notes: every wait is bounded
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, attach = 1'b1, digital_rst = 1'b0, present;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb = 4'hF;
  int mismatches = 0, total_checks = 0, cyc = 0;
  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  ecc_eeprom_model u_ecc_eeprom_model (.aclk(aclk), .attach(attach), .present(present));
  ecc_top #(.LOAD_CYC(4), .TIMEOUT_CYC(40)) u_ecc_top (
    .aclk(aclk), .aresetn(aresetn), .eeprom_present(present), .digital_rst(digital_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    mismatches++;
    wrap_up();
  endtask
  // aw and w offered together, each released when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    // one idle edge so bready is never driven twice in one time step
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n >= 200) hang();
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n >= 200) hang();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr({20'h0, a}, d, r);
    chk({30'h0, r}, {30'h0, ecc_pkg::RESP_OKAY});
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd({20'h0, a}, d, r);
  endtask
  // polls busy; returns cycles spent until it read clear
  task automatic wait_idle(output int cycles);
    logic [31:0] d;
    int n, t0;
    t0 = cyc;
    d = 32'hFFFF_FFFF;
    for (n = 0; n < 200 && d[ecc_pkg::BUSY_BIT] !== 1'b0; n++) rd(ecc_pkg::CMD_OFF, d);
    if (n >= 200) hang();
    cycles = cyc - t0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    int c;
    rd(ecc_pkg::CMD_OFF, d);
    chk({31'h0, d[31]}, 32'h1);
    chk({29'h0, d[30:28]}, {29'h0, ecc_pkg::OP_RESET});
    wait_idle(c);
  endtask
  task automatic t_write();
    logic [31:0] d;
    int c;
    wr(ecc_pkg::BYTE_OFF, 32'h0000_00A5);
    wr(ecc_pkg::CMD_OFF, 32'hB000_0012);
    rd(ecc_pkg::CMD_OFF, d);
    chk({31'h0, d[31]}, 32'h1);
    wait_idle(c);
    chk({31'h0, c >= 32}, 32'h1);
    rd(ecc_pkg::STAT_OFF, d);
    chk({31'h0, d[0]}, 32'h0);
  endtask
  task automatic t_read();
    logic [31:0] d;
    int c;
    wr(ecc_pkg::BYTE_OFF, 32'h0000_0000);
    wr(ecc_pkg::CMD_OFF, 32'h8000_0012);
    wait_idle(c);
    chk({31'h0, c >= 32}, 32'h1);
    rd(ecc_pkg::BYTE_OFF, d);
    chk(d, 32'h0000_00A5);
  endtask
  task automatic t_absent();
    logic [31:0] d;
    int c;
    attach <= 1'b0;
    repeat (3) @(posedge aclk);
    wr(ecc_pkg::CMD_OFF, 32'hB000_0034);
    wait_idle(c);
    chk({31'h0, c >= 40}, 32'h1);
    rd(ecc_pkg::STAT_OFF, d);
    chk({31'h0, d[0]}, 32'h1);
    wr(ecc_pkg::STAT_OFF, 32'h0000_0001);
    rd(ecc_pkg::STAT_OFF, d);
    chk({31'h0, d[0]}, 32'h0);
    attach <= 1'b1;
  endtask
  task automatic t_strobe();
    logic [31:0] d;
    wstrb <= 4'h3;
    wr(ecc_pkg::CMD_OFF, 32'h8000_0056);
    wstrb <= 4'hF;
    rd(ecc_pkg::CMD_OFF, d);
    chk(d, 32'h0000_0056);
  endtask
  task automatic t_reserved();
    int c;
    wr(ecc_pkg::CMD_OFF, 32'h9000_0000);
    wait_idle(c);
    chk({31'h0, c < 32}, 32'h1);
  endtask
  task automatic t_digital();
    logic [31:0] d;
    int c;
    digital_rst <= 1'b1;
    repeat (4) @(posedge aclk);
    digital_rst <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(ecc_pkg::CMD_OFF, d);
    chk({31'h0, d[31]}, 32'h1);
    wait_idle(c);
  endtask
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(32'h0000_0100, d, r);
    chk({30'h0, r}, {30'h0, ecc_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    axi_wr(32'h0000_0100, 32'h0, r);
    chk({30'h0, r}, {30'h0, ecc_pkg::RESP_SLVERR});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_absent();
    t_reserved();
    t_digital();
    t_strobe();
    t_unmapped();
    wrap_up();
  end
endmodule // tb_top
